// >>> core/mls_dev_end.sv
// Behaviour
// RULE1 - Current ceiling: write 0x42, read 0x02.
// RULE2 - Ceiling follows pot; pot change reloads it.
// RULE3 - Lock stops pot overwriting tracked registers.
// RULE4 - All values cleared at restart; unlocked pot-tracked ones reload from their pot on the first cycle after.
// RULE5 - Values are 12-bit, 0 to 4095.
// RULE6 - Regen ceiling 0x43/0x03, tracks its pot.
// RULE7 - Rise ramp 0x44/0x04, tracks ramp pot.
// RULE8 - Fall ramp 0x45/0x05, disabled by default.
// RULE9 - Host never writes fall ramp below one.
// RULE10 - Armed undervolt trip shuts outputs down.
// RULE11 - Undervolt shutdown sets low-supply status.
// RULE12 - Armed undervolt recover level ends low state.
// RULE13 - Armed overvolt recover level ends high state.
// RULE14 - Armed overvolt trip shuts outputs down.
// RULE15 - Protection may overwrite overvolt trip level.
// RULE16 - Overvolt shutdown sets high-supply status.
// RULE17 - Supply reading read-only at 0x10.
// RULE18 - Data as two 7-bit bytes, high first.
// RULE19 - Trip state held until recovery crossing; the code also clears it as soon as its trip level is disarmed.
`include "mls_regs.svh"

module mls_dev_end
	import mls_pkg::*;
#(
	parameter int VAL_W = 12,
	parameter int NPOT  = 3
)
(
	input  wire logic                          core_clk,
	input  wire logic                          reset,
	mls_link_if.dev                            link,
	input  wire logic [NPOT-1:0][VAL_W-1:0]    pot_level,
	input  wire logic [7:0]                    lock_bits,
	input  wire logic [VAL_W-1:0]              supply_level,
	input  wire logic                          ovp_load,
	input  wire logic [VAL_W-1:0]              ovp_level,
	output logic      [7:0][VAL_W-1:0]         param_value,
	output logic      [7:0]                    param_written,
	output logic                               fall_ramp_en,
	output logic                               low_supply,
	output logic                               high_supply,
	output logic                               outputs_off
);

	localparam int NREG = 8;
	localparam logic [`MLS_WORD_W-1:0] VAL_MAX = `MLS_WORD_W'((1 << VAL_W) - 1);

	// ------------------------------------------------------------------------
	// Parameter check and code decoding
	// ------------------------------------------------------------------------
	if (VAL_W < 1 || VAL_W > `MLS_WORD_W || NPOT < 0 || NPOT > NREG ||
		NREG != int'(`MLS_LAST_RW - `MLS_FIRST_RW) + 1)
	begin : g_bad
		$error("mls_dev_end: unsupported parameters.");
	end
	function automatic logic rw_hit(input logic [`MLS_CODE_MSB:0] code);
		return (code >= `MLS_FIRST_RW) && (code <= `MLS_LAST_RW);
	endfunction : rw_hit

	function automatic logic [2:0] rw_index(input logic [`MLS_CODE_MSB:0] code);
		return 3'(code - `MLS_FIRST_RW);
	endfunction : rw_index

	localparam logic [2:0] IDX_FALL = rw_index(`MLS_CODE_FALL);
	localparam logic [2:0] IDX_UVT  = rw_index(`MLS_CODE_UVT);
	localparam logic [2:0] IDX_UVR  = rw_index(`MLS_CODE_UVR);
	localparam logic [2:0] IDX_OVR  = rw_index(`MLS_CODE_OVR);
	localparam logic [2:0] IDX_OVT  = rw_index(`MLS_CODE_OVT);

	mls_dev_state_t           state_q;
	logic [`MLS_CODE_MSB:0]   cmd_q;
	logic [`MLS_PAY_W-1:0]    hi_q;
	logic [`MLS_PAY_W-1:0]    tx_lo_q;
	mls_byte_t                tx_q;
	logic [NREG-1:0][VAL_W-1:0] val_q;
	logic [NREG-1:0]          written_q;
	logic [NREG-1:0]          pot_chg;
	logic [NREG-1:0][VAL_W-1:0] pot_val;
	logic                     rx_take;
	logic                     tx_take;
	logic                     wr_go;
	logic [`MLS_WORD_W-1:0]   wr_word;
	logic [VAL_W-1:0]         wr_sat;
	logic [`MLS_WORD_W-1:0]   rd_word;
	logic [`MLS_CODE_MSB:0]   rx_code;
	logic                     low_q;
	logic                     high_q;

	// ------------------------------------------------------------------------
	// Link handshake
	// ------------------------------------------------------------------------
	assign link.h2d_ready = (state_q == MLS_D_IDLE) || (state_q == MLS_D_WHI) || (state_q == MLS_D_WLO);
	assign link.d2h_valid = (state_q == MLS_D_RHI) || (state_q == MLS_D_RLO);
	assign link.d2h_data  = tx_q;
	assign rx_take        = link.h2d_valid && link.h2d_ready;
	assign tx_take        = link.d2h_valid && link.d2h_ready;
	assign rx_code        = link.h2d_data[`MLS_CODE_MSB:0];

	// Two seven-bit payloads joined, out-of-range values saturate.
	assign wr_word = {hi_q, link.h2d_data[`MLS_LO_MSB:0]}; // RULE18
	assign wr_sat  = (wr_word > VAL_MAX) ? VAL_MAX[VAL_W-1:0] : wr_word[VAL_W-1:0]; // RULE5
	assign wr_go   = (state_q == MLS_D_WLO) && rx_take && rw_hit(cmd_q);

	always_comb
	begin
		rd_word = '0;
		if (rw_hit(rx_code))
			rd_word = `MLS_WORD_W'(val_q[rw_index(rx_code)]); // RULE1
		else if (rx_code == `MLS_CODE_SUPPLY)
			rd_word = `MLS_WORD_W'(supply_level); // RULE17
	end

	// ------------------------------------------------------------------------
	// Command sequencer
	// ------------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_q <= MLS_D_IDLE;
			cmd_q   <= '0;
			hi_q    <= '0;
			tx_q    <= '0;
			tx_lo_q <= '0;
		end
		else
		begin
			case (state_q)
				MLS_D_IDLE:
				begin
					if (rx_take && !link.h2d_data[`MLS_MARK_BIT])
					begin
						cmd_q <= rx_code;
						if (link.h2d_data[`MLS_WR_BIT])
							state_q <= MLS_D_WHI;
						else
						begin
							tx_q    <= {1'b0, rd_word[`MLS_HI_MSB:`MLS_HI_LSB]}; // RULE18
							tx_lo_q <= rd_word[`MLS_LO_MSB:0];
							state_q <= MLS_D_RHI;
						end
					end
				end
				MLS_D_WHI:
				begin
					if (rx_take)
					begin
						hi_q    <= link.h2d_data[`MLS_LO_MSB:0]; // RULE18
						state_q <= MLS_D_WLO;
					end
				end
				MLS_D_WLO:
				begin
					if (rx_take)
						state_q <= MLS_D_IDLE;
				end
				MLS_D_RHI:
				begin
					if (tx_take)
					begin
						tx_q    <= {1'b0, tx_lo_q}; // RULE18
						state_q <= MLS_D_RLO;
					end
				end
				MLS_D_RLO:
				begin
					if (tx_take)
						state_q <= MLS_D_IDLE;
				end
				default:
					state_q <= MLS_D_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------------
	// Potentiometer tracking and parameter registers
	// ------------------------------------------------------------------------
	for (genvar p = 0; p < NREG; p++)
	begin : g_pot
		if (p < NPOT)
		begin : g_track
			logic [VAL_W-1:0] prev_q;
			logic             seen_q;
			always_ff @(posedge core_clk)
			begin
				if (reset)
				begin
					prev_q <= '0;
					seen_q <= `MLS_RESET_VAL;
				end
				else
				begin
					prev_q <= pot_level[p];
					seen_q <= 1'b1;
				end
			end
			// The first cycle after restart loads the pot unless its lock bit is set.
			assign pot_chg[p] = !seen_q || (pot_level[p] != prev_q); // RULE2 RULE6 RULE7
			assign pot_val[p] = pot_level[p];
		end
		else
		begin : g_none
			assign pot_chg[p] = 1'b0;
			assign pot_val[p] = '0;
		end
	end

	for (genvar i = 0; i < NREG; i++)
	begin : g_reg
		always_ff @(posedge core_clk)
		begin
			if (reset)
			begin
				val_q[i]     <= '0; // RULE4
				written_q[i] <= `MLS_RESET_VAL;
			end
			else if (i == int'(IDX_OVT) && ovp_load)
				val_q[i] <= ovp_level; // RULE15
			else if (wr_go && rw_index(cmd_q) == 3'(i))
			begin
				val_q[i]     <= wr_sat; // RULE1 RULE6 RULE7 RULE8
				written_q[i] <= 1'b1;
			end
			else if (pot_chg[i] && !lock_bits[i]) // RULE3
				val_q[i] <= pot_val[i]; // RULE2
		end
	end

	assign param_value   = val_q;
	assign param_written = written_q;
	assign fall_ramp_en  = written_q[IDX_FALL] && (val_q[IDX_FALL] != '0); // RULE8

	// ------------------------------------------------------------------------
	// Supply supervisor
	// ------------------------------------------------------------------------
	logic uvt_arm;
	logic uvr_arm;
	logic ovt_arm;
	logic ovr_arm;
	assign uvt_arm = written_q[IDX_UVT] && lock_bits[IDX_UVT]; // RULE10
	assign uvr_arm = written_q[IDX_UVR] && lock_bits[IDX_UVR]; // RULE12
	assign ovt_arm = written_q[IDX_OVT] && lock_bits[IDX_OVT]; // RULE14
	assign ovr_arm = written_q[IDX_OVR] && lock_bits[IDX_OVR]; // RULE13

	always_ff @(posedge core_clk)
	begin
		if (reset)
			low_q <= `MLS_RESET_VAL;
		else if (uvt_arm && supply_level < val_q[IDX_UVT])
			low_q <= 1'b1; // RULE10 RULE11
		else if (!uvt_arm || supply_level > (uvr_arm ? val_q[IDX_UVR] : val_q[IDX_UVT]))
			low_q <= 1'b0; // RULE12 RULE19
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			high_q <= `MLS_RESET_VAL;
		else if (ovt_arm && supply_level > val_q[IDX_OVT])
			high_q <= 1'b1; // RULE14 RULE16
		else if (!ovt_arm || supply_level < (ovr_arm ? val_q[IDX_OVR] : val_q[IDX_OVT]))
			high_q <= 1'b0; // RULE13 RULE19
	end

	assign low_supply  = low_q;
	assign high_supply = high_q;
	assign outputs_off = low_q || high_q; // RULE10 RULE14

endmodule : mls_dev_end

// >>> core/mls_regs.svh
`ifndef MLS_REGS_SVH
`define MLS_REGS_SVH

// ----------------------------------------------------------------------------
// Command codes (read codes; a write sets the write flag bit)
// ----------------------------------------------------------------------------
`define MLS_CODE_CUR      6'h02
`define MLS_CODE_REGEN    6'h03
`define MLS_CODE_RISE     6'h04
`define MLS_CODE_FALL     6'h05
`define MLS_CODE_UVT      6'h06
`define MLS_CODE_UVR      6'h07
`define MLS_CODE_OVR      6'h08
`define MLS_CODE_OVT      6'h09
`define MLS_CODE_SUPPLY   6'h10
`define MLS_FIRST_RW      6'h02
`define MLS_LAST_RW       6'h09

// ----------------------------------------------------------------------------
// Command byte layout
// ----------------------------------------------------------------------------
`define MLS_MARK_BIT      7
`define MLS_WR_BIT        6
`define MLS_CODE_MSB      5

// ----------------------------------------------------------------------------
// Data word split over two bytes
// ----------------------------------------------------------------------------
`define MLS_WORD_W        14
`define MLS_HI_MSB        13
`define MLS_HI_LSB        7
`define MLS_LO_MSB        6
`define MLS_PAY_W         7

// ----------------------------------------------------------------------------
// Values
// ----------------------------------------------------------------------------
`define MLS_FALL_MIN      14'h0001
`define MLS_RESET_VAL     1'b0

`endif

// >>> core/mls_pkg.sv
`include "mls_regs.svh"

package mls_pkg;

	// ------------------------------------------------------------------------
	// State types
	// ------------------------------------------------------------------------
	typedef enum logic [2:0]
	{
		MLS_D_IDLE,
		MLS_D_WHI,
		MLS_D_WLO,
		MLS_D_RHI,
		MLS_D_RLO
	} mls_dev_state_t;

	typedef enum logic [2:0]
	{
		MLS_H_IDLE,
		MLS_H_CMD,
		MLS_H_DHI,
		MLS_H_DLO,
		MLS_H_RHI,
		MLS_H_RLO
	} mls_host_state_t;

	typedef logic [7:0] mls_byte_t;

endpackage : mls_pkg

// >>> core/mls_link_if.sv
interface mls_link_if;
	import mls_pkg::*;

	// ------------------------------------------------------------------------
	// Byte streams in both directions
	// ------------------------------------------------------------------------
	logic      h2d_valid;
	mls_byte_t h2d_data;
	logic      h2d_ready;
	logic      d2h_valid;
	mls_byte_t d2h_data;
	logic      d2h_ready;

	modport dev
	(
		input  h2d_valid,
		input  h2d_data,
		output h2d_ready,
		output d2h_valid,
		output d2h_data,
		input  d2h_ready
	);

	modport host
	(
		output h2d_valid,
		output h2d_data,
		input  h2d_ready,
		input  d2h_valid,
		input  d2h_data,
		output d2h_ready
	);

endinterface : mls_link_if

// >>> core/mls_host_end.sv
`include "mls_regs.svh"

module mls_host_end
	import mls_pkg::*;
(
	input  wire logic                    core_clk,
	input  wire logic                    reset,
	mls_link_if.host                     link,
	input  wire logic                    req_valid,
	output logic                         req_ready,
	input  wire logic                    req_write,
	input  wire logic [`MLS_CODE_MSB:0]  req_code,
	input  wire logic [`MLS_WORD_W-1:0]  req_wdata,
	output logic                         rsp_valid,
	output logic [`MLS_WORD_W-1:0]       rsp_data
);

	mls_host_state_t          state_q;
	mls_byte_t                out_q;
	logic [`MLS_WORD_W-1:0]   data_q;
	logic [`MLS_PAY_W-1:0]    rhi_q;
	logic                     rsp_valid_q;
	logic [`MLS_WORD_W-1:0]   rsp_data_q;
	logic                     tx_take;
	logic                     rx_take;

	// ------------------------------------------------------------------------
	// Handshakes
	// ------------------------------------------------------------------------
	assign req_ready      = (state_q == MLS_H_IDLE);
	assign link.h2d_valid = (state_q == MLS_H_CMD) || (state_q == MLS_H_DHI) || (state_q == MLS_H_DLO);
	assign link.h2d_data  = out_q;
	assign link.d2h_ready = (state_q == MLS_H_RHI) || (state_q == MLS_H_RLO);
	assign tx_take        = link.h2d_valid && link.h2d_ready;
	assign rx_take        = link.d2h_valid && link.d2h_ready;
	assign rsp_valid      = rsp_valid_q;
	assign rsp_data       = rsp_data_q;

	// ------------------------------------------------------------------------
	// Transfer sequencer
	// ------------------------------------------------------------------------
	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state_q     <= MLS_H_IDLE;
			out_q       <= '0;
			data_q      <= '0;
			rhi_q       <= '0;
			rsp_valid_q <= 1'b0;
			rsp_data_q  <= '0;
		end
		else
		begin
			rsp_valid_q <= 1'b0;
			case (state_q)
				MLS_H_IDLE:
				begin
					if (req_valid)
					begin
						out_q <= {1'b0, req_write, req_code}; // RULE1 RULE6
						if (req_write && req_code == `MLS_CODE_FALL && req_wdata < `MLS_FALL_MIN)
						begin
							data_q <= `MLS_FALL_MIN; // RULE9
						end
						else
						begin
							data_q <= req_wdata;
						end
						state_q <= MLS_H_CMD;
					end
				end
				MLS_H_CMD:
				begin
					if (tx_take)
					begin
						out_q   <= {1'b0, data_q[`MLS_HI_MSB:`MLS_HI_LSB]}; // RULE18
						state_q <= out_q[`MLS_WR_BIT] ? MLS_H_DHI : MLS_H_RHI;
					end
				end
				MLS_H_DHI:
				begin
					if (tx_take)
					begin
						out_q   <= {1'b0, data_q[`MLS_LO_MSB:0]}; // RULE18
						state_q <= MLS_H_DLO;
					end
				end
				MLS_H_DLO:
				begin
					if (tx_take)
					begin
						state_q <= MLS_H_IDLE;
					end
				end
				MLS_H_RHI:
				begin
					if (rx_take)
					begin
						rhi_q   <= link.d2h_data[`MLS_LO_MSB:0];
						state_q <= MLS_H_RLO;
					end
				end
				MLS_H_RLO:
				begin
					if (rx_take)
					begin
						rsp_data_q  <= {rhi_q, link.d2h_data[`MLS_LO_MSB:0]}; // RULE18
						rsp_valid_q <= 1'b1;
						state_q     <= MLS_H_IDLE;
					end
				end
				default:
				begin
					state_q <= MLS_H_IDLE;
				end
			endcase
		end
	end

endmodule : mls_host_end

// >>> tb/mls_link_chk.sv
`include "mls_regs.svh"

module mls_link_chk
	import mls_pkg::*;
(
	input  wire logic      core_clk,
	input  wire logic      reset,
	input  wire logic      h2d_valid,
	input  wire mls_byte_t h2d_data,
	input  wire logic      h2d_ready,
	input  wire logic      d2h_valid,
	input  wire mls_byte_t d2h_data,
	input  wire logic      d2h_ready
);
	timeunit 1ns;
	timeprecision 1ps;

	// ------------------------------------------------------------------------
	// Command byte tracking
	// ------------------------------------------------------------------------
	logic [1:0] wr_left_q;
	logic       h_take;
	logic       cmd_take;

	assign h_take   = h2d_valid && h2d_ready;
	assign cmd_take = h_take && (wr_left_q == 2'h0);

	always_ff @(posedge core_clk)
	begin
		if (reset)
			wr_left_q <= 2'h0;
		else if (cmd_take && h2d_data[6] && !h2d_data[7])
			wr_left_q <= 2'h2;
		else if (h_take && (wr_left_q != 2'h0))
			wr_left_q <= wr_left_q - 2'h1;
	end

	// ------------------------------------------------------------------------
	// Link checks
	// ------------------------------------------------------------------------
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);

	hold_h2d_a: assert property (h2d_valid && !h2d_ready |=> h2d_valid && $stable(h2d_data))
		else $error("host byte changed before taken");
	hold_d2h_a: assert property (d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_data))
		else $error("device byte changed before taken");
	h2d_top_a: assert property (h2d_valid |-> !h2d_data[7])
		else $error("host byte top bit set");
	d2h_top_a: assert property (d2h_valid |-> !d2h_data[7])
		else $error("device byte top bit set");
	reply_busy_a: assert property (d2h_valid |-> !h2d_ready)
		else $error("device accepts while replying");
	read_reply_a: assert property (cmd_take && !h2d_data[6] |=> (d2h_valid && d2h_ready)[*2] ##1 !d2h_valid)
		else $error("read reply not two bytes");
	reply_width_a: assert property (cmd_take && !h2d_data[6] |=> d2h_data[6:5] == 2'b00)
		else $error("reply exceeds twelve bits");
	write_data_a: assert property (cmd_take && h2d_data[6] |=> (h2d_valid && h2d_ready)[*2])
		else $error("write data bytes missing");
	fall_min_a: assert property (cmd_take && h2d_data == {2'b01, `MLS_CODE_FALL} |=> ##1 (h2d_data[`MLS_LO_MSB:0] != 7'h00 || $past(h2d_data[`MLS_LO_MSB:0]) != 7'h00))
		else $error("fall ramp written as zero");

	read_c: cover property (cmd_take && !h2d_data[6]);
	write_c: cover property (cmd_take && h2d_data[6]);
	supply_c: cover property (cmd_take && h2d_data[5:0] == 6'h10);

endmodule : mls_link_chk

// >>> tb/testbench.sv
module testbench
	import mls_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic             core_clk;
	logic             reset;
	logic [2:0][11:0] pot_level;
	logic [7:0]       lock_bits;
	logic [11:0]      supply_level;
	logic             ovp_load;
	logic [11:0]      ovp_level;
	logic [7:0][11:0] param_value;
	logic [7:0]       param_written;
	logic             fall_ramp_en;
	logic             low_supply;
	logic             high_supply;
	logic             outputs_off;
	logic             req_valid;
	logic             req_ready;
	logic             req_write;
	logic [5:0]       req_code;
	logic [13:0]      req_wdata;
	logic             rsp_valid;
	logic [13:0]      rsp_data;
	logic [13:0]      rd;
	int               error_cnt = 0;
	int               n_tests = 0;
	logic [11:0]      sup_v[7] = '{12'h44c, 12'h384, 12'h44c, 12'h514, 12'hc1c, 12'hb54, 12'ha8c};
	logic [1:0]       sup_e[7] = '{2'b00, 2'b01, 2'b01, 2'b00, 2'b10, 2'b10, 2'b00};

	mls_link_if link();

	mls_dev_end #(.VAL_W(12), .NPOT(3)) mls_dev_end_i (.core_clk(core_clk), .reset(reset), .link(link),
		.pot_level(pot_level), .lock_bits(lock_bits), .supply_level(supply_level), .ovp_load(ovp_load),
		.ovp_level(ovp_level), .param_value(param_value), .param_written(param_written),
		.fall_ramp_en(fall_ramp_en), .low_supply(low_supply), .high_supply(high_supply),
		.outputs_off(outputs_off));

	mls_host_end mls_host_end_i (.core_clk(core_clk), .reset(reset), .link(link), .req_valid(req_valid),
		.req_ready(req_ready), .req_write(req_write), .req_code(req_code), .req_wdata(req_wdata),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data));

	mls_link_chk mls_link_chk_i (.core_clk(core_clk), .reset(reset), .h2d_valid(link.h2d_valid),
		.h2d_data(link.h2d_data), .h2d_ready(link.h2d_ready), .d2h_valid(link.d2h_valid),
		.d2h_data(link.d2h_data), .d2h_ready(link.d2h_ready));

	initial
	begin
		core_clk = 1'b0;
		forever #20 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------------
	task automatic chk(input string name, input logic [13:0] got, input logic [13:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic xfer(input logic wr, input logic [5:0] code, input logic [13:0] wd);
		int n;
		n = 0;
		req_valid <= 1'b1;
		req_write <= wr;
		req_code <= code;
		req_wdata <= wd;
		@(negedge core_clk);
		while (req_ready !== 1'b1 && n < 50)
		begin
			@(negedge core_clk);
			n++;
		end
		@(posedge core_clk);
		req_valid <= 1'b0;
		@(negedge core_clk);
		while (((wr && req_ready !== 1'b1) || (!wr && rsp_valid !== 1'b1)) && n < 100)
		begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 50)
			error_cnt++;
		rd = rsp_data;
		@(posedge core_clk);
	endtask : xfer

	task automatic rd_chk(input string name, input logic [5:0] code, input logic [13:0] exp);
		xfer(1'b0, code, 14'h0000);
		chk(name, rd, exp);
	endtask : rd_chk

	task automatic restart();
		reset <= 1'b1;
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask : restart

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		#(40 * 20000);
		error_cnt++;
		tally_and_finish();
	end

	// ------------------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------------------
	initial
	begin
		reset = 1'b1;
		req_valid = 1'b0;
		req_write = 1'b0;
		req_code = 6'h00;
		req_wdata = 14'h0000;
		pot_level = {12'h789, 12'h456, 12'h123};
		lock_bits = 8'h00;
		supply_level = 12'h400;
		ovp_load = 1'b0;
		ovp_level = 12'h000;
		restart();
		for (int i = 2; i <= 9; i++)
			rd_chk("reset value", 6'(i), (i < 5) ? {2'b00, pot_level[i - 2]} : 14'h0000);
		chk("fall enable", 14'(fall_ramp_en), 14'h0000);
		chk("written", 14'(param_written), 14'h0000);
		$display("test reset done");
		for (int i = 2; i <= 9; i++)
		begin
			xfer(1'b1, 6'(i), 14'(i * 341));
			rd_chk("readback", 6'(i), 14'(i * 341));
		end
		chk("fall enable", 14'(fall_ramp_en), 14'h0001);
		chk("written", 14'(param_written), 14'h00ff);
		xfer(1'b1, 6'h05, 14'h0000);
		rd_chk("fall minimum", 6'h05, 14'h0001);
		xfer(1'b1, 6'h02, 14'h3fff);
		rd_chk("saturate", 6'h02, 14'h0fff);
		pot_level[0] <= 12'h321;
		repeat (3) @(posedge core_clk);
		rd_chk("pot reload", 6'h02, 14'h0321);
		lock_bits <= 8'h02;
		xfer(1'b1, 6'h03, 14'h0abc);
		pot_level[1] <= 12'h654;
		repeat (3) @(posedge core_clk);
		rd_chk("locked", 6'h03, 14'h0abc);
		chk("regen port", 14'(param_value[1]), 14'h0abc);
		$display("test override done");
		supply_level <= 12'habc;
		repeat (3) @(posedge core_clk);
		rd_chk("supply", 6'h10, 14'h0abc);
		xfer(1'b1, 6'h10, 14'h0123);
		rd_chk("supply ro", 6'h10, 14'h0abc);
		rd_chk("unmapped", 6'h11, 14'h0000);
		$display("test supply done");
		lock_bits <= 8'hf2;
		xfer(1'b1, 6'h06, 14'h03e8);
		xfer(1'b1, 6'h07, 14'h04b0);
		xfer(1'b1, 6'h09, 14'h0bb8);
		xfer(1'b1, 6'h08, 14'h0af0);
		for (int i = 0; i < 7; i++)
		begin
			supply_level <= sup_v[i];
			repeat (3) @(posedge core_clk);
			chk("supply state", {12'h000, high_supply, low_supply}, {12'h000, sup_e[i]});
			chk("outputs off", 14'(outputs_off), 14'(sup_e[i] != 2'b00));
		end
		ovp_level <= 12'h9c4;
		ovp_load <= 1'b1;
		@(posedge core_clk);
		ovp_load <= 1'b0;
		rd_chk("protection load", 6'h09, 14'h09c4);
		$display("test voltage done");
		lock_bits <= 8'h00;
		restart();
		rd_chk("restart pot", 6'h02, 14'h0321);
		rd_chk("restart fall", 6'h05, 14'h0000);
		chk("restart low", 14'(low_supply), 14'(0));
		chk("restart written", 14'(param_written), 14'h0000);
		$display("test restart done");
		tally_and_finish();
	end

endmodule : testbench
